// ==== sfr_regs.svh ====
/*
  Shared constants of the serial flash read link: opcodes, phase lengths,
  wrap field layout, reset values, host register map and link timing.
  Assumes it is included by the package and by both link end modules.
*/
`ifndef SFR_REGS_SVH
`define SFR_REGS_SVH

// ---------------------------------------------------------------
// Opcodes
// ---------------------------------------------------------------
`define SFR_OP_FAST 8'h0B
`define SFR_OP_DOUT 8'h3B
`define SFR_OP_DIO 8'hBB
`define SFR_OP_QOUT 8'h6B
`define SFR_OP_QIO 8'hEB
`define SFR_OP_QWORD 8'hE7
`define SFR_OP_QOCT 8'hE3
`define SFR_OP_WRAP 8'h77

// ---------------------------------------------------------------
// Phase lengths in link clocks
// ---------------------------------------------------------------
`define SFR_CMD_CLKS 6'h08
`define SFR_ADDR_CLKS_1 6'h18
`define SFR_ADDR_CLKS_2 6'h0C
`define SFR_ADDR_CLKS_4 6'h06
`define SFR_WRAP_CLKS 6'h20
`define SFR_DUMMY_FAST 6'h08
`define SFR_DUMMY_DIO 6'h04
`define SFR_DUMMY_QIO 6'h06
`define SFR_DUMMY_QWORD 6'h02
`define SFR_MODE_CLKS 6'h02
`define SFR_CONT_MODE 2'h2

// ---------------------------------------------------------------
// Wrap field and reset values
// ---------------------------------------------------------------
`define SFR_WRAP_EN_N_BIT 4
`define SFR_WRAP_SEL_LSB 5
`define SFR_WRAP_BASE_LEN 8'h08
`define SFR_WRAP_EN_N_RST 1'h1
`define SFR_WRAP_SEL_RST 2'h0
`define SFR_CS_SYNC_RST 2'h3

// ---------------------------------------------------------------
// Host register map and link timing
// ---------------------------------------------------------------
`define SFR_HREG_ADDR 5'h00
`define SFR_HREG_CMD 5'h04
`define SFR_HREG_LEN 5'h08
`define SFR_HREG_STAT 5'h0C
`define SFR_HREG_DATA 5'h10
`define SFR_CMD_AUX_LSB 8
`define SFR_CMD_SKIP_BIT 16
`define SFR_MCLK_PERIOD_NS 10
`define SFR_SCLK_PERIOD_NS 160
`define SFR_SCLK_HALF_CYC (`SFR_SCLK_PERIOD_NS / (2 * `SFR_MCLK_PERIOD_NS))
`endif

// ==== sfr_pkg.sv ====
/*
  Types and opcode decode helpers shared by both link ends.
  Assumes sfr_regs.svh is reachable by its bare name.
*/
`include "sfr_regs.svh"
package sfr_pkg;
  typedef enum logic [2:0] {SFR_D_IDLE, SFR_D_CMD, SFR_D_ADDR, SFR_D_DUMMY, SFR_D_DATA, SFR_D_WRAP,
                            SFR_D_IGNORE} sfr_dev_state_type;
  typedef enum logic [2:0] {SFR_H_IDLE, SFR_H_CMD, SFR_H_ADDR, SFR_H_DUMMY, SFR_H_DATA,
                            SFR_H_END} sfr_host_state_type;

  typedef struct packed {
    sfr_dev_state_type st;
    logic [1:0] cs_s;
    logic [2:0] sclk_s;
    logic [3:0] lane_a;
    logic [3:0] lane_b;
    logic [7:0] op;
    logic [5:0] cnt;
    logic [23:0] sh;
    logic [7:0] mode;
    logic [2:0] ph;
    logic [7:0] obyte;
    logic [23:0] addr;
    logic [3:0] o;
    logic [3:0] oe;
    logic wrap_en_n;
    logic [1:0] wrap_sel;
    logic cont;
  } sfr_dev_reg_type;

  typedef struct packed {
    sfr_host_state_type st;
    logic [3:0] lane_a;
    logic [3:0] lane_b;
    logic cs_n;
    logic sclk;
    logic [3:0] o;
    logic [3:0] oe;
    logic [3:0] div;
    logic [5:0] cnt;
    logic [39:0] tx;
    logic [7:0] rx;
    logic [3:0] rxc;
    logic [15:0] left;
    logic [7:0] op;
    logic [7:0] aux;
    logic [23:0] addr;
    logic [15:0] len;
    logic [7:0] data;
    logic valid;
    logic busy;
    logic [31:0] rd_data;
  } sfr_host_reg_type;

  // Lanes used by the address phase
  function automatic logic [2:0] sfr_addr_lanes(input logic [7:0] op);
    case (op)
      `SFR_OP_DIO: sfr_addr_lanes = 3'h2;
      `SFR_OP_QIO, `SFR_OP_QWORD, `SFR_OP_QOCT: sfr_addr_lanes = 3'h4;
      default: sfr_addr_lanes = 3'h1;
    endcase
  endfunction

  // Lanes used by the data phase
  function automatic logic [2:0] sfr_data_lanes(input logic [7:0] op);
    case (op)
      `SFR_OP_DOUT, `SFR_OP_DIO: sfr_data_lanes = 3'h2;
      `SFR_OP_QOUT, `SFR_OP_QIO, `SFR_OP_QWORD, `SFR_OP_QOCT: sfr_data_lanes = 3'h4;
      default: sfr_data_lanes = 3'h1;
    endcase
  endfunction

  // Dummy clocks between address and data
  function automatic logic [5:0] sfr_dummy_clks(input logic [7:0] op);
    case (op)
      `SFR_OP_FAST, `SFR_OP_DOUT, `SFR_OP_QOUT: sfr_dummy_clks = `SFR_DUMMY_FAST;
      `SFR_OP_DIO: sfr_dummy_clks = `SFR_DUMMY_DIO;
      `SFR_OP_QIO: sfr_dummy_clks = `SFR_DUMMY_QIO;
      `SFR_OP_QWORD: sfr_dummy_clks = `SFR_DUMMY_QWORD;
      default: sfr_dummy_clks = 6'h00;
    endcase
  endfunction

  // Address phase length, wrap setup carries its wrap byte too
  function automatic logic [5:0] sfr_addr_clks(input logic [7:0] op);
    if (op == `SFR_OP_WRAP) begin
      sfr_addr_clks = `SFR_WRAP_CLKS;
    end else begin
      case (sfr_addr_lanes(op))
        3'h2: sfr_addr_clks = `SFR_ADDR_CLKS_2;
        3'h4: sfr_addr_clks = `SFR_ADDR_CLKS_4;
        default: sfr_addr_clks = `SFR_ADDR_CLKS_1;
      endcase
    end
  endfunction

  function automatic logic sfr_is_quad(input logic [7:0] op);
    sfr_is_quad = (op == `SFR_OP_QOUT) || (op == `SFR_OP_QIO) || (op == `SFR_OP_QWORD) || (op == `SFR_OP_QOCT);
  endfunction

  function automatic logic sfr_is_read(input logic [7:0] op);
    sfr_is_read = (op == `SFR_OP_FAST) || (op == `SFR_OP_DOUT) || (op == `SFR_OP_DIO) || sfr_is_quad(op);
  endfunction

  // Reads that obey the stored wrap setting
  function automatic logic sfr_wraps(input logic [7:0] op);
    sfr_wraps = (op == `SFR_OP_QIO) || (op == `SFR_OP_QWORD);
  endfunction

  // Shift lane bits in, most significant lane first
  function automatic logic [23:0] sfr_shin24(input logic [23:0] sh, input logic [3:0] din,
                                            input logic [2:0] lanes);
    case (lanes)
      3'h2: sfr_shin24 = {sh[21:0], din[1:0]};
      3'h4: sfr_shin24 = {sh[19:0], din};
      default: sfr_shin24 = {sh[22:0], din[0]};
    endcase
  endfunction
endpackage

// ==== sfr_link_if.sv ====
/*
  Link between the flash host and the flash device: chip select, serial
  clock and four shared data lanes. Assumes the lanes idle high when undriven.
*/
`timescale 1ns/1ps
interface sfr_link_if;
  logic cs_n;
  logic sclk;
  logic [3:0] host_o;
  logic [3:0] host_oe;
  logic [3:0] dev_o;
  logic [3:0] dev_oe;
  logic [3:0] lane;

  // Wire level: device drive first, then host, else pull-up
  assign lane = (dev_oe & dev_o) | (~dev_oe & host_oe & host_o) | (~dev_oe & ~host_oe);

  modport host (output cs_n, output sclk, output host_o, output host_oe, input lane);
  modport dev (input cs_n, input sclk, input lane, output dev_o, output dev_oe);
endinterface

// ==== sfr_dev.sv ====
/*
  Flash end of the multi-lane read link: command decode, address and dummy
  phases, byte streaming with linear or wrapped addressing, wrap setup.
  Assumes array data arrive on rd_data within two mclk cycles of rd_addr,
  and that the link clock runs well below a quarter of mclk.
*/
`timescale 1ns/1ps
`include "sfr_regs.svh"
module sfr_dev
  import sfr_pkg::*;
(
  sfr_link_if.dev link,
  input wire logic mclk,
  input wire logic srst,
  input wire logic write_in_progress_bit,
  input wire logic quad_enable_bit,
  input wire logic [7:0] rd_data,
  output logic [23:0] rd_addr,
  output logic wrap_enable_n,
  output logic [1:0] wrap_length_sel,
  output logic execute_in_place
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  localparam sfr_dev_reg_type DEV_RST = '{
    st: SFR_D_IDLE,
    cs_s: `SFR_CS_SYNC_RST,
    wrap_en_n: `SFR_WRAP_EN_N_RST,
    wrap_sel: `SFR_WRAP_SEL_RST,
    default: '0
  };

  sfr_dev_reg_type r;
  sfr_dev_reg_type n;
  logic rise;
  logic fall;
  logic [3:0] din;
  logic [2:0] dl;
  logic [7:0] ob;
  logic [7:0] mask;
  logic [23:0] linear;
  logic [23:0] next_addr;

  // ---------------------------------------------------------------
  // Next address
  // ---------------------------------------------------------------
  // Linear count rolls over, wrapped count stays in its section
  always_comb begin
    mask = (`SFR_WRAP_BASE_LEN << r.wrap_sel) - 8'h01;
    linear = r.addr + 24'h000001;
    if (sfr_wraps(r.op) && !r.wrap_en_n) begin
      next_addr = {r.addr[23:8], (r.addr[7:0] & ~mask) | (linear[7:0] & mask)};
    end else begin
      next_addr = linear;
    end
  end

  // ---------------------------------------------------------------
  // Protocol engine
  // ---------------------------------------------------------------
  // Synchronise link pins, find clock edges, step the phases
  always_comb begin
    n = r;
    n.cs_s = {r.cs_s[0], link.cs_n};
    n.sclk_s = {r.sclk_s[1:0], link.sclk};
    n.lane_a = link.lane;
    n.lane_b = r.lane_a;
    rise = r.sclk_s[1] & ~r.sclk_s[2];
    fall = ~r.sclk_s[1] & r.sclk_s[2];
    din = r.lane_b;
    dl = sfr_data_lanes(r.op);
    ob = (r.ph == 3'h0) ? rd_data : r.obyte;
    if (r.cs_s[1]) begin
      n.st = SFR_D_IDLE;
      n.oe = 4'h0;
      n.ph = 3'h0;
    end else begin
      case (r.st)
        SFR_D_IDLE: begin
          if (r.cont) begin
            n.st = SFR_D_ADDR;
            n.op = `SFR_OP_QIO;
            n.cnt = `SFR_ADDR_CLKS_4;
          end else begin
            n.st = SFR_D_CMD;
            n.cnt = `SFR_CMD_CLKS;
          end
        end
        SFR_D_CMD: begin
          if (rise) begin
            n.sh = sfr_shin24(r.sh, din, 3'h1);
            n.cnt = r.cnt - 6'h01;
            if (r.cnt == 6'h01) begin
              n.op = n.sh[7:0];
              if (n.sh[7:0] == `SFR_OP_WRAP) begin
                n.st = SFR_D_WRAP;
                n.cnt = `SFR_WRAP_CLKS;
              end else if (!sfr_is_read(n.sh[7:0])) begin
                n.st = SFR_D_IGNORE;
              end else if (write_in_progress_bit) begin
                n.st = SFR_D_IGNORE;
              end else if (sfr_is_quad(n.sh[7:0]) && !quad_enable_bit) begin
                n.st = SFR_D_IGNORE;
              end else begin
                n.st = SFR_D_ADDR;
                n.cnt = sfr_addr_clks(n.sh[7:0]);
              end
            end
          end
        end
        SFR_D_ADDR: begin
          if (rise) begin
            n.sh = sfr_shin24(r.sh, din, sfr_addr_lanes(r.op));
            n.cnt = r.cnt - 6'h01;
            if (r.cnt == 6'h01) begin
              n.addr = n.sh;
              if (r.op == `SFR_OP_QWORD) begin
                n.addr[0] = 1'b0;
              end
              if (r.op == `SFR_OP_QOCT) begin
                n.addr[3:0] = 4'h0;
              end
              n.mode = 8'h00;
              n.ph = 3'h0;
              if (sfr_dummy_clks(r.op) == 6'h00) begin
                n.st = SFR_D_DATA;
              end else begin
                n.st = SFR_D_DUMMY;
                n.cnt = sfr_dummy_clks(r.op);
              end
            end
          end
        end
        SFR_D_DUMMY: begin
          if (rise) begin
            n.cnt = r.cnt - 6'h01;
            if ((r.op == `SFR_OP_QIO) && (r.cnt > (`SFR_DUMMY_QIO - `SFR_MODE_CLKS))) begin
              n.mode = {r.mode[3:0], din};
            end
            if (r.cnt == 6'h01) begin
              n.st = SFR_D_DATA;
              if (r.op == `SFR_OP_QIO) begin
                n.cont = (n.mode[5:4] == `SFR_CONT_MODE);
              end
            end
          end
        end
        SFR_D_DATA: begin
          if (fall) begin
            case (dl)
              3'h2: begin
                n.o = {2'b00, ob[7:6]};
                n.oe = 4'h3;
              end
              3'h4: begin
                n.o = ob[7:4];
                n.oe = 4'hF;
              end
              default: begin
                n.o = {2'b00, ob[7], 1'b0};
                n.oe = 4'h2;
              end
            endcase
            n.obyte = ob << dl;
            if (r.ph == 3'h0) begin
              n.addr = next_addr;
            end
            n.ph = (r.ph == (3'h7 >> dl[2:1])) ? 3'h0 : r.ph + 3'h1;
          end
        end
        SFR_D_WRAP: begin
          if (rise) begin
            n.sh = sfr_shin24(r.sh, din, 3'h1);
            n.cnt = r.cnt - 6'h01;
            if (r.cnt == 6'h01) begin
              n.wrap_en_n = n.sh[`SFR_WRAP_EN_N_BIT];
              n.wrap_sel = n.sh[`SFR_WRAP_SEL_LSB +: 2];
              n.st = SFR_D_IGNORE;
            end
          end
        end
        SFR_D_IGNORE: begin
          n.oe = 4'h0;
        end
        default: begin
          n.st = SFR_D_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers and outputs
  // ---------------------------------------------------------------
  // Single register stage for all state
  always_ff @(posedge mclk) begin
    if (srst) begin
      r <= DEV_RST;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign link.dev_o = r.o;
  assign link.dev_oe = r.oe;
  assign rd_addr = r.addr;
  assign wrap_enable_n = r.wrap_en_n;
  assign wrap_length_sel = r.wrap_sel;
  assign execute_in_place = r.cont;

endmodule // sfr_dev

// ==== sfr_host.sv ====
/*
  Host end of the multi-lane read link: register port for software, link
  clock divider, command, address, dummy and data phases, received bytes.
  Assumes software starts a command only while the busy flag is clear.
*/
`timescale 1ns/1ps
`include "sfr_regs.svh"
module sfr_host
  import sfr_pkg::*;
(
  sfr_link_if.host link,
  input wire logic mclk,
  input wire logic srst,
  input wire logic [4:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rd_data
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  localparam logic [3:0] HALF_LAST = 4'(`SFR_SCLK_HALF_CYC - 1);
  localparam sfr_host_reg_type HOST_RST = '{st: SFR_H_IDLE, cs_n: 1'b1, default: '0};

  sfr_host_reg_type r;
  sfr_host_reg_type n;
  logic [2:0] cl;
  logic [2:0] dl;
  logic [3:0] din;
  logic [23:0] rxn;
  logic [3:0] rxsum;

  // Lane drive pattern and enables for the top tx bits
  function automatic logic [7:0] drive(input logic [3:0] top, input logic [2:0] lanes);
    case (lanes)
      3'h2: drive = {4'h3, 2'b00, top[3:2]};
      3'h4: drive = {4'hF, top};
      default: drive = {4'h1, 3'h0, top[3]};
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Register port and sequencer
  // ---------------------------------------------------------------
  // Reads first so a byte landing in the same cycle keeps its flag
  always_comb begin
    n = r;
    n.lane_a = link.lane;
    n.lane_b = r.lane_a;
    n.rd_data = 32'h00000000;
    cl = (r.st == SFR_H_ADDR) ? sfr_addr_lanes(r.op) : ((r.st == SFR_H_CMD) ? 3'h1 : 3'h4);
    dl = sfr_data_lanes(r.op);
    din = (dl == 3'h1) ? {3'h0, r.lane_b[1]} : r.lane_b;
    rxn = sfr_shin24({16'h0000, r.rx}, din, dl);
    rxsum = r.rxc + {1'b0, dl};
    if (rd_stb) begin
      case (addr)
        `SFR_HREG_ADDR: n.rd_data = {8'h00, r.addr};
        `SFR_HREG_CMD: n.rd_data = {16'h0000, r.aux, r.op};
        `SFR_HREG_LEN: n.rd_data = {16'h0000, r.len};
        `SFR_HREG_STAT: n.rd_data = {30'h0, r.valid, r.busy};
        `SFR_HREG_DATA: begin
          n.rd_data = {23'h0, r.valid, r.data};
          n.valid = 1'b0;
        end
        default: n.rd_data = 32'h00000000;
      endcase
    end
    if (wr_stb && (addr == `SFR_HREG_ADDR)) begin
      n.addr = wdata[23:0];
    end
    if (wr_stb && (addr == `SFR_HREG_LEN)) begin
      n.len = wdata[15:0];
    end
    if (!r.busy) begin
      if (wr_stb && (addr == `SFR_HREG_CMD)) begin
        n.busy = 1'b1;
        n.cs_n = 1'b0;
        n.sclk = 1'b0;
        n.div = 4'h0;
        n.left = r.len;
        n.rxc = 4'h0;
        n.aux = wdata[`SFR_CMD_AUX_LSB +: 8];
        if (wdata[`SFR_CMD_SKIP_BIT]) begin
          n.op = `SFR_OP_QIO;
          n.st = SFR_H_ADDR;
          n.cnt = `SFR_ADDR_CLKS_4;
          n.tx = {r.addr, n.aux, 8'h00};
          {n.oe, n.o} = drive(n.tx[39:36], 3'h4);
        end else begin
          n.op = wdata[7:0];
          n.st = SFR_H_CMD;
          n.cnt = `SFR_CMD_CLKS;
          // Wrap byte as software gives it
          n.tx = {n.op, r.addr, n.aux};
          {n.oe, n.o} = drive(n.tx[39:36], 3'h1);
        end
      end
    end else if (r.div != HALF_LAST) begin
      n.div = r.div + 4'h1;
    end else begin
      n.div = 4'h0;
      if (r.st == SFR_H_END) begin
        n.st = SFR_H_IDLE;
        n.busy = 1'b0;
      end else if (!r.sclk) begin
        // Rising edge: device samples, host takes data
        n.sclk = 1'b1;
        if (r.st == SFR_H_DATA) begin
          if (rxsum == 4'h8) begin
            n.data = rxn[7:0];
            n.valid = 1'b1;
            n.rxc = 4'h0;
            n.left = r.left - 16'h0001;
            if (r.left <= 16'h0001) begin
              n.cnt = 6'h00;
            end
          end else begin
            n.rx = rxn[7:0];
            n.rxc = rxsum;
          end
        end else begin
          n.cnt = r.cnt - 6'h01;
        end
      end else begin
        // Falling edge: host moves to the next bits
        n.sclk = 1'b0;
        n.tx = r.tx << cl;
        if (r.cnt != 6'h00) begin
          if ((r.st == SFR_H_CMD) || (r.st == SFR_H_ADDR)) begin
            {n.oe, n.o} = drive(n.tx[39:36], cl);
          end else if ((r.st == SFR_H_DUMMY) && (r.op == `SFR_OP_QIO) &&
                       (r.cnt == (`SFR_DUMMY_QIO - 6'h01))) begin
            {n.oe, n.o} = drive(n.tx[39:36], 3'h4);
          end else begin
            n.oe = 4'h0;
          end
        end else begin
          case (r.st)
            SFR_H_CMD: begin
              if ((r.op == `SFR_OP_WRAP) || sfr_is_read(r.op)) begin
                n.st = SFR_H_ADDR;
                n.cnt = sfr_addr_clks(r.op);
                {n.oe, n.o} = drive(n.tx[39:36], sfr_addr_lanes(r.op));
              end else begin
                n.st = SFR_H_END;
              end
            end
            SFR_H_ADDR: begin
              if (!sfr_is_read(r.op)) begin
                n.st = SFR_H_END;
              end else if (sfr_dummy_clks(r.op) != 6'h00) begin
                n.st = SFR_H_DUMMY;
                n.cnt = sfr_dummy_clks(r.op);
                if (r.op == `SFR_OP_QIO) begin
                  {n.oe, n.o} = drive(n.tx[39:36], 3'h4);
                end else begin
                  n.oe = 4'h0;
                end
              end else begin
                n.st = SFR_H_DATA;
                n.cnt = 6'h01;
                n.oe = 4'h0;
              end
            end
            SFR_H_DUMMY: begin
              n.st = SFR_H_DATA;
              n.cnt = 6'h01;
              n.oe = 4'h0;
            end
            default: begin
              n.st = SFR_H_END;
            end
          endcase
          if (n.st == SFR_H_END) begin
            n.cs_n = 1'b1;
            n.oe = 4'h0;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers and outputs
  // ---------------------------------------------------------------
  // Single register stage for all state
  always_ff @(posedge mclk) begin
    if (srst) begin
      r <= HOST_RST;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign link.cs_n = r.cs_n;
  assign link.sclk = r.sclk;
  assign link.host_o = r.o;
  assign link.host_oe = r.oe;
  assign rd_data = r.rd_data;

endmodule // sfr_host

// ==== sfr_link_sva.sv ====
/* Link checker: timing relations on the shared lanes.
   Assumes it sits beside the link instance in the mclk domain. */
`timescale 1ns/1ps
module sfr_link_sva (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] host_oe,
  input wire logic [3:0] dev_o,
  input wire logic [3:0] dev_oe
);
  // ----
  // Link relations
  // ----
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_desel; cs_n [*5]; endsequence
  sequence s_clk_hi; sclk [*8] ##1 !sclk; endsequence
  desel_rel_a: assert property (s_desel |-> dev_oe == 4'h0) else $error("lanes held after deselect");
  clk_idle_a: assert property (cs_n ##1 cs_n |-> !sclk) else $error("clock runs while deselected");
  half_period_a: assert property ($rose(sclk) |-> s_clk_hi) else $error("clock high phase length");
  no_clash_a: assert property ((host_oe & dev_oe) == 4'h0) else $error("both ends drive a lane");
  lane_set_a: assert property (dev_oe inside {4'h0, 4'h2, 4'h3, 4'hF}) else $error("bad lane set");
  opcode_quiet_a: assert property ($fell(cs_n) |-> (dev_oe == 4'h0) [*8]) else $error("lanes driven early");
  host_off_a: assert property ($rose(dev_oe != 4'h0) |-> $past(host_oe) == 4'h0) else $error("host drives");
  fall_shift_a: assert property (dev_oe != 4'h0 && $changed(dev_o) |-> !sclk) else $error("data moved high");
endmodule // sfr_link_sva

// ==== serial_flash_multi_io_read_tb_top.sv ====
/* Bench: host and flash ends on one link, queue model of bytes.
   Assumes the shared header and package are compiled first. */
`timescale 1ns/1ps
`include "sfr_regs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("ERROR %s exp %h got %h", n, e, g); end end
module serial_flash_multi_io_read_tb_top;
  // ----
  // Setup
  // ----
  logic mclk = 0, srst = 1, wr_stb = 0, rd_stb = 0, wr_cycle = 0, quad_en = 1;
  logic m_wen = 1, m_cont = 0, wen_n, cont_rd, bad;
  logic [1:0] m_sel = 0, wsel;
  logic [4:0] addr = 0;
  logic [7:0] arr = 0, key;
  logic [23:0] rd_addr;
  logic [31:0] wdata = 0, rd_data, v;
  logic [7:0] ops [7] = '{8'h0B, 8'h3B, 8'hBB, 8'h6B, 8'hEB, 8'hE7, 8'hE3};
  logic [7:0] q[$];
  integer seed = 32'hd8638447, n_errors = 0, cmp_count = 0, i, j, k, s, ad, msk;
  sfr_link_if link ();
  sfr_host sfr_host_inst (.link(link), .mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data));
  sfr_dev sfr_dev_inst (.link(link), .mclk(mclk), .srst(srst), .write_in_progress_bit(wr_cycle),
    .quad_enable_bit(quad_en), .rd_data(arr), .rd_addr(rd_addr), .wrap_enable_n(wen_n),
    .wrap_length_sel(wsel), .execute_in_place(cont_rd));
  sfr_link_sva sfr_link_sva_inst (.mclk(mclk), .srst(srst), .cs_n(link.cs_n), .sclk(link.sclk),
    .host_oe(link.host_oe), .dev_o(link.dev_o), .dev_oe(link.dev_oe));
  // Clock and array contents
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) arr <= rd_addr[7:0] ^ rd_addr[23:16] ^ key;
  // Register port cycles
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 v = rd_data;
  endtask
  // One command: issue, model bytes, compare each byte
  task automatic run(input logic [31:0] c, input logic [23:0] a, input integer n);
    // Issue first, so level inputs set at the calling edge have settled
    wr(`SFR_HREG_ADDR, {8'h0, a});
    wr(`SFR_HREG_LEN, n);
    wr(`SFR_HREG_CMD, c);
    bad = wr_cycle || (!quad_en && c[7:0] inside {8'h6B, 8'hEB, 8'hE7, 8'hE3});
    s = c[7:0] == 8'hE7 ? a & 24'hFFFFFE : c[7:0] == 8'hE3 ? a & 24'hFFFFF0 : a;
    msk = (8 << m_sel) - 1;
    for (k = 0; k < n; k++) begin
      ad = (c[7:0] inside {8'hEB, 8'hE7} && !m_wen) ? (s & ~msk) | ((s + k) & msk) : (s + k) & 24'hFFFFFF;
      q.push_back(bad ? 8'hFF : ad[7:0] ^ ad[23:16] ^ key);
    end
    if (c[7:0] == 8'h77) begin
      m_wen = c[12];
      m_sel = c[14:13];
    end
    if (c[7:0] == 8'hEB && !bad) m_cont = c[13:12] == 2'h2;
    while (q.size() > 0) begin
      i = 0;
      do rd(`SFR_HREG_DATA); while (v[8] !== 1'b1 && i++ < 1000);
      `CHK("data", {1'b1, q.pop_front()}, v[8:0])
    end
    i = 0;
    do rd(`SFR_HREG_STAT); while (v[0] !== 1'b0 && i++ < 1000);
    `CHK("idle", 1'b0, v[0])
    `CHK("mode", {m_wen, m_sel, m_cont}, {wen_n, wsel, cont_rd})
    $display("test %h done", c);
  endtask
  // Verdict
  task automatic final_report;
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (80000) @(posedge mclk);
    n_errors++;
    final_report;
  end
  // Main sequence
  initial begin
    key = 8'($random(seed));
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    rd(5'h14);
    `CHK("unmapped", 32'h0, v)
    run(32'h0B, 24'hFFFFFE, 4);
    foreach (ops[j]) run({24'h0, ops[j]}, 24'($random(seed)), 1 + ($random(seed) & 3));
    for (j = 0; j < 4; j++) begin
      run({16'h0, 1'b0, j[1:0], 5'h0, 8'h77}, 24'h0, 0);
      run({24'h0, 8'hEB ^ {4'h0, j[0], j[0], 2'h0}}, 24'($random(seed)), 10);
    end
    run(32'h1077, 24'h0, 0);
    run(32'hE7, 24'($random(seed)), 5);
    run(32'h20EB, 24'($random(seed)), 3);
    run(32'h100EB, 24'($random(seed)), 3);
    @(posedge mclk) quad_en <= 1'b0;
    run(32'h6B, 24'($random(seed)), 2);
    run(32'hEB, 24'($random(seed)), 2);
    @(posedge mclk) quad_en <= 1'b1;
    @(posedge mclk) wr_cycle <= 1'b1;
    run(32'h3B, 24'($random(seed)), 2);
    @(posedge mclk) wr_cycle <= 1'b0;
    final_report;
  end
endmodule // serial_flash_multi_io_read_tb_top
